//--- common/sfr_map_pkg.sv
package sfr_map_pkg;

    typedef enum logic [4:0] {
        SEL_NONE,
        SEL_INDIRECT,
        SEL_TIMER,
        SEL_PC_LOW,
        SEL_FLAGS,
        SEL_POINTER,
        SEL_PORT_A,
        SEL_PORT_B,
        SEL_PC_LATCH,
        SEL_IRQ_CTRL,
        SEL_PERIPH_FLAGS,
        SEL_COMPARATOR,
        SEL_OPTIONS,
        SEL_DIR_A,
        SEL_DIR_B,
        SEL_PERIPH_EN,
        SEL_RESET_CAUSE,
        SEL_SERIAL_MEM,
        SEL_VREF
    } sfr_sel_t;

    localparam logic [7:0] ADDR_INDIRECT_B0     = 8'h00;
    localparam logic [7:0] ADDR_TIMER           = 8'h01;
    localparam logic [7:0] ADDR_PC_LOW_B0       = 8'h02;
    localparam logic [7:0] ADDR_FLAGS_B0        = 8'h03;
    localparam logic [7:0] ADDR_POINTER_B0      = 8'h04;
    localparam logic [7:0] ADDR_PORT_A          = 8'h05;
    localparam logic [7:0] ADDR_PORT_B          = 8'h06;
    localparam logic [7:0] ADDR_PC_LATCH_B0     = 8'h0a;
    localparam logic [7:0] ADDR_IRQ_CTRL_B0     = 8'h0b;
    localparam logic [7:0] ADDR_PERIPH_FLAGS    = 8'h0c;
    localparam logic [7:0] ADDR_COMPARATOR      = 8'h1f;
    localparam logic [7:0] ADDR_INDIRECT_B1     = 8'h80;
    localparam logic [7:0] ADDR_OPTIONS         = 8'h81;
    localparam logic [7:0] ADDR_PC_LOW_B1       = 8'h82;
    localparam logic [7:0] ADDR_FLAGS_B1        = 8'h83;
    localparam logic [7:0] ADDR_POINTER_B1      = 8'h84;
    localparam logic [7:0] ADDR_DIR_A           = 8'h85;
    localparam logic [7:0] ADDR_DIR_B           = 8'h86;
    localparam logic [7:0] ADDR_PC_LATCH_B1     = 8'h8a;
    localparam logic [7:0] ADDR_IRQ_CTRL_B1     = 8'h8b;
    localparam logic [7:0] ADDR_PERIPH_EN       = 8'h8c;
    localparam logic [7:0] ADDR_RESET_CAUSE     = 8'h8e;
    localparam logic [7:0] ADDR_SERIAL_MEM      = 8'h90;
    localparam logic [7:0] ADDR_VREF            = 8'h9f;

    // core flags bit positions and values
    localparam int         FLAG_C               = 0;
    localparam int         FLAG_DC              = 1;
    localparam int         FLAG_Z               = 2;
    localparam int         FLAG_PD              = 3;
    localparam int         FLAG_TO              = 4;
    localparam logic [7:0] FLAGS_POR            = 8'h18;

    // reset cause register
    localparam int         CAUSE_BROWNOUT       = 0;
    localparam logic [7:0] CAUSE_MASK           = 8'h03;
    localparam logic [7:0] CAUSE_POR            = 8'h00;

    // program counter
    localparam int         PC_WIDTH             = 13;
    localparam int         PC_LATCH_WIDTH       = 5;
    localparam logic [7:0] PC_LOW_POR           = 8'h00;

    // plain storage registers: implemented bits, power-on value, bits kept on other resets
    localparam int PLAIN_COUNT = 13;
    localparam int IDX_POINTER = 1;
    localparam int IDX_IRQ     = 4;
    localparam int IDX_OPTIONS = 7;
    localparam int IDX_DIR_A   = 8;
    localparam int IDX_DIR_B   = 9;
    localparam sfr_sel_t PLAIN_SEL [PLAIN_COUNT] = '{
        SEL_TIMER, SEL_POINTER, SEL_PORT_A, SEL_PORT_B, SEL_IRQ_CTRL, SEL_PERIPH_FLAGS,
        SEL_COMPARATOR, SEL_OPTIONS, SEL_DIR_A, SEL_DIR_B, SEL_PERIPH_EN,
        SEL_SERIAL_MEM, SEL_VREF};
    localparam logic [7:0] PLAIN_MASK [PLAIN_COUNT] = '{
        8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h40, 8'hcf, 8'hff, 8'h1f, 8'hff, 8'h40,
        8'h07, 8'hef};
    localparam logic [7:0] PLAIN_POR [PLAIN_COUNT] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h1f, 8'hff, 8'h00,
        8'h07, 8'h00};
    localparam logic [7:0] PLAIN_KEEP [PLAIN_COUNT] = '{
        8'hff, 8'hff, 8'h10, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};

endpackage

//--- verification/core_special_register_map_tb.sv
`timescale 1ns/1ns
module core_special_register_map_tb
    import sfr_map_pkg::*;
;
    logic                sys_clk, rst, soft_rst, wdt_reset_cause, brownout_cause, wr_en;
    logic                sub_op, alu_z, alu_dc, alu_c, sleep_evt, clrwdt_evt, wdt_timeout_evt;
    logic                pc_inc;
    logic [2:0]          flag_upd_mask;
    logic [7:0]          rd_addr, wr_addr, wr_data, rd_data_q, core_flags, indirect_pointer;
    logic [7:0]          interrupt_control, core_options, port_a_direction, port_b_direction;
    logic [PC_WIDTH-1:0] program_counter;
    logic [31:0]         seed;
    int                  model [256];
    int                  pa [PLAIN_COUNT] = '{1, 4, 5, 6, 11, 12, 31, 129, 133, 134, 140,
                                              144, 159};
    int                  ul [8] = '{3, 2, 10, 142, 7, 141, 32, 0};
    int                  evl [4] = '{1, 4, 2, 7};
    int                  pc, n_fail, checked;

    core_special_register_map core_special_register_map_inst (
        .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst), .wdt_reset_cause(wdt_reset_cause),
        .brownout_cause(brownout_cause), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .flag_upd_mask(flag_upd_mask), .alu_z(alu_z), .alu_dc(alu_dc),
        .alu_c(alu_c), .sub_op(sub_op), .sleep_evt(sleep_evt), .clrwdt_evt(clrwdt_evt),
        .wdt_timeout_evt(wdt_timeout_evt), .pc_inc(pc_inc), .rd_data_q(rd_data_q),
        .core_flags(core_flags), .program_counter(program_counter),
        .indirect_pointer(indirect_pointer), .interrupt_control(interrupt_control),
        .core_options(core_options), .port_a_direction(port_a_direction),
        .port_b_direction(port_b_direction));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // locations shared by both banks fold onto their bank 0 address
    function automatic int am(int a);
        int b;
        b = a & 127;
        return (b inside {0, 2, 3, 4, 10, 11}) ? b : a;
    endfunction

    function automatic int mk(int a);
        int m;
        m = (am(a) == 2) ? 255 : (am(a) == 10) ? 31 : (a == 142) ? 3 : 0;
        for (int i = 0; i < PLAIN_COUNT; i++)
            if (am(a) == pa[i]) m = PLAIN_MASK[i];
        return m;
    endfunction

    function automatic int rexp(int a);
        int t;
        t = am(a);
        if (t == 0) t = am(model[4]);
        return (t == 2) ? (pc & 255) : (t == 0) ? 0 : model[t];
    endfunction

    task automatic chk(string n, logic [15:0] e, logic [15:0] v);
        checked++;
        if (v !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, v);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // alu is {sub, z, dc, c}; raw borrows come in on dc and c
    task automatic op(int a, int d, logic [2:0] m, logic [3:0] alu);
        int t, f;
        @(posedge sys_clk);
        {wr_en, wr_addr, wr_data, flag_upd_mask, sub_op, alu_z, alu_dc, alu_c} <=
            {1'b1, 8'(a), 8'(d), m, alu};
        @(posedge sys_clk);
        {wr_en, flag_upd_mask} <= 4'h0;
        t = am(a);
        if (t == 0) t = (am(model[4]) == 0) ? -1 : am(model[4]);
        f = model[3];
        if (t == 3) f = (d & ((m != 0) ? 8'he0 : 8'he7)) | (f & ((m != 0) ? 8'h1f : 8'h18));
        else if (t == 2) pc = (model[10] << 8) | (d & 255);
        else if (t > 0) model[t] = d & mk(t);
        if (m[2]) f[2] = alu[2];
        if (m[1]) f[1] = alu[1] ^ alu[3];
        if (m[0]) f[0] = alu[0] ^ alu[3];
        model[3] = f;
    endtask

    // e is {inc, timeout, clrwdt, sleep}
    task automatic ev(logic [3:0] e);
        @(posedge sys_clk);
        {pc_inc, wdt_timeout_evt, clrwdt_evt, sleep_evt} <= e;
        @(posedge sys_clk);
        {pc_inc, wdt_timeout_evt, clrwdt_evt, sleep_evt} <= 4'h0;
        if (e[1]) model[3] = model[3] | 8'h18;
        if (e[0]) model[3] = (model[3] & 8'hf7) | 8'h10;
        if (e[2]) model[3] = model[3] & 8'hef;
        if (e[3]) pc = (pc + 1) & 16'h1fff;
    endtask

    task automatic sr(logic w, logic b);
        @(posedge sys_clk);
        {soft_rst, wdt_reset_cause, brownout_cause} <= {1'b1, w, b};
        @(posedge sys_clk);
        {soft_rst, wdt_reset_cause, brownout_cause} <= 3'b000;
        model[3] = (model[3] & (w ? 8'h07 : 8'h1f)) | (w ? 8'h08 : 8'h00);
        for (int i = 0; i < PLAIN_COUNT; i++)
            model[pa[i]] = (model[pa[i]] & PLAIN_KEEP[i]) | (PLAIN_POR[i] & ~PLAIN_KEEP[i]);
        model[142] = model[142] & (b ? 2 : 3);
        model[10] = 0;
        pc = 0;
    endtask

    task automatic rd(int a);
        @(posedge sys_clk);
        rd_addr <= 8'(a);
        @(posedge sys_clk);
        #1;
        chk("rd_data_q", 16'(rexp(a)), {8'h00, rd_data_q});
        chk("program_counter", 16'(pc), 16'(program_counter));
        chk("flags_dir_b", 16'((model[3] << 8) | model[134]),
            {core_flags, port_b_direction});
        chk("pointer_irq", 16'((model[4] << 8) | model[11]),
            {indirect_pointer, interrupt_control});
        chk("options_dir_a", 16'((model[129] << 8) | model[133]),
            {core_options, port_a_direction});
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        conclude();
    end

    initial
    begin
        int a;
        {rst, soft_rst, wdt_reset_cause, brownout_cause, wr_en, sub_op, alu_z, alu_dc} = 8'h80;
        {alu_c, sleep_evt, clrwdt_evt, wdt_timeout_evt, pc_inc} = 5'h00;
        {rd_addr, wr_addr, wr_data, flag_upd_mask} = 27'h0;
        seed = 32'habe5d522;
        for (int i = 0; i < PLAIN_COUNT; i++)
            model[pa[i]] = PLAIN_POR[i];
        model[3] = FLAGS_POR;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (pa[i]) rd(pa[i]);
        foreach (ul[i]) rd(ul[i]);
        $display("test reset_values done");
        for (int k = 0; k < 40; k++)
        begin
            a = pa[rnd() % PLAIN_COUNT];
            op(a, rnd() & 255, 3'b000, 4'h0);
            rd((am(a ^ 128) == am(a)) ? a ^ 128 : a);
        end
        for (int k = 4; k < 7; k++)
        begin
            op(ul[k], 255, 3'b000, 4'h0);
            rd(ul[k]);
        end
        $display("test random_storage done");
        op(4, 133, 3'b000, 4'h0);
        op(0, 170, 3'b000, 4'h0);
        rd(128);
        op(132, 128, 3'b000, 4'h0);
        op(128, 85, 3'b000, 4'h0);
        rd(0);
        $display("test indirect done");
        op(3, 0, 3'b000, 4'h0);
        rd(131);
        op(131, 63, 3'b000, 4'h0);
        rd(3);
        op(131, 0, 3'b100, 4'b0100);
        rd(3);
        op(3, 0, 3'b011, 4'b1001);
        rd(3);
        op(1, 7, 3'b111, 4'b1110);
        rd(131);
        foreach (evl[i])
        begin
            ev(4'(evl[i]));
            rd(3);
        end
        $display("test flags done");
        op(138, 243, 3'b000, 4'h0);
        rd(10);
        op(2, 64, 3'b000, 4'h0);
        ev(4'b1000);
        rd(130);
        op(10, 5, 3'b000, 4'h0);
        rd(2);
        $display("test program_counter done");
        op(142, 3, 3'b000, 4'h0);
        op(129, 0, 3'b000, 4'h0);
        rd(142);
        sr(1'b1, 1'b1);
        rd(142);
        rd(3);
        ev(4'b0001);
        sr(1'b0, 1'b0);
        rd(132);
        $display("test soft_reset done");
        conclude();
    end
endmodule

//--- verilog/core_flags_unit.sv
`timescale 1ns/1ns
module core_flags_unit
    import sfr_map_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       soft_rst,
    input  wire logic       wdt_reset_cause,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic [2:0] upd_mask,
    input  wire logic       alu_z,
    input  wire logic       alu_dc,
    input  wire logic       alu_c,
    input  wire logic       sub_op,
    input  wire logic       sleep_evt,
    input  wire logic       clrwdt_evt,
    input  wire logic       wdt_timeout_evt,
    output logic      [7:0] flags_q
);

    logic [7:0] flags_d;
    logic [2:0] alu_res;
    logic [2:0] low_src;
    logic [2:0] upper_d;
    logic       to_d;
    logic       pd_d;
    logic       no_evt;

    // subtraction delivers borrows; the stored flags are their inverses
    assign alu_res = {alu_z, sub_op ? ~alu_dc : alu_dc, sub_op ? ~alu_c : alu_c};
    // a flag-updating result blocks the data write to all three result bits
    assign low_src = (wr_en && upd_mask == 3'b000) ? wr_data[2:0] : flags_q[2:0];
    assign upper_d = wr_en ? wr_data[7:5] : flags_q[7:5];
    // outside reset, sleep, clear-watchdog and time-out alone move the two power flags
    assign to_d    = wdt_timeout_evt ? 1'b0 :
                     (sleep_evt | clrwdt_evt) ? 1'b1 : flags_q[FLAG_TO];
    assign pd_d    = sleep_evt ? 1'b0 : clrwdt_evt ? 1'b1 : flags_q[FLAG_PD];
    assign no_evt  = !sleep_evt && !clrwdt_evt && !wdt_timeout_evt;
    assign flags_d = {upper_d, to_d, pd_d,
                      (upd_mask & alu_res) | (~upd_mask & low_src)};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            flags_q <= FLAGS_POR;
        else if (soft_rst)
            flags_q <= {3'b000, wdt_reset_cause ? 2'b01 : flags_q[4:3], flags_q[2:0]};
        else
            flags_q <= flags_d;
    end

    sequence flag_write_s;
        wr_en && !soft_rst && no_evt;
    endsequence

    AST_FLAGS_FROM_RESULT: assert property (@(posedge sys_clk) disable iff (rst)
        flag_write_s and upd_mask == 3'b111 |=> flags_q[2:0] == $past(alu_res))
        else $error("result flags did not override the data write");
    AST_POWER_FLAGS_LOCKED: assert property (@(posedge sys_clk) disable iff (rst)
        flag_write_s |=> flags_q[4:3] == $past(flags_q[4:3]))
        else $error("power flags changed by an instruction write");
    AST_CLEAR_PATTERN: assert property (@(posedge sys_clk) disable iff (rst)
        flag_write_s and wr_data == 8'h00 && upd_mask == 3'b100 && alu_z
        |=> flags_q == {3'b000, $past(flags_q[4:3]), 1'b1, $past(flags_q[1:0])})
        else $error("clear of flags register gave wrong pattern");
    AST_BORROW_INVERTED: assert property (@(posedge sys_clk) disable iff (rst)
        !soft_rst && sub_op && upd_mask[0] && upd_mask[1]
        |=> flags_q[0] == !$past(alu_c) && flags_q[1] == !$past(alu_dc))
        else $error("borrow not stored inverted");
    AST_PLAIN_DEST: assert property (@(posedge sys_clk) disable iff (rst)
        flag_write_s and upd_mask == 3'b000
        |=> {flags_q[7:5], flags_q[2:0]} == {$past(wr_data[7:5]), $past(wr_data[2:0])})
        else $error("flags register not written as data");
    AST_SOFT_FLAGS: assert property (@(posedge sys_clk) disable iff (rst)
        soft_rst |=> flags_q[7:5] == 3'b000 && flags_q[2:0] == $past(flags_q[2:0]))
        else $error("other reset value of flags wrong");

endmodule

//--- verilog/core_special_register_map.sv
`timescale 1ns/1ns
module core_special_register_map
    import sfr_map_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                soft_rst,
    input  wire logic                wdt_reset_cause,
    input  wire logic                brownout_cause,
    input  wire logic [7:0]          rd_addr,
    input  wire logic                wr_en,
    input  wire logic [7:0]          wr_addr,
    input  wire logic [7:0]          wr_data,
    input  wire logic [2:0]          flag_upd_mask,
    input  wire logic                alu_z,
    input  wire logic                alu_dc,
    input  wire logic                alu_c,
    input  wire logic                sub_op,
    input  wire logic                sleep_evt,
    input  wire logic                clrwdt_evt,
    input  wire logic                wdt_timeout_evt,
    input  wire logic                pc_inc,
    output logic      [7:0]          rd_data_q,
    output logic      [7:0]          core_flags,
    output logic      [PC_WIDTH-1:0] program_counter,
    output logic      [7:0]          indirect_pointer,
    output logic      [7:0]          interrupt_control,
    output logic      [7:0]          core_options,
    output logic      [7:0]          port_a_direction,
    output logic      [7:0]          port_b_direction
);

    // mirrored core registers decode to one selector from either bank
    function automatic sfr_sel_t decode_sel(input logic [7:0] a);
        sfr_sel_t s;
        s = SEL_NONE;
        case (a)
            ADDR_INDIRECT_B0, ADDR_INDIRECT_B1: s = SEL_INDIRECT;
            ADDR_PC_LOW_B0,   ADDR_PC_LOW_B1:   s = SEL_PC_LOW;
            ADDR_FLAGS_B0,    ADDR_FLAGS_B1:    s = SEL_FLAGS;
            ADDR_POINTER_B0,  ADDR_POINTER_B1:  s = SEL_POINTER;
            ADDR_PC_LATCH_B0, ADDR_PC_LATCH_B1: s = SEL_PC_LATCH;
            ADDR_IRQ_CTRL_B0, ADDR_IRQ_CTRL_B1: s = SEL_IRQ_CTRL;
            ADDR_TIMER:        s = SEL_TIMER;
            ADDR_PORT_A:       s = SEL_PORT_A;
            ADDR_PORT_B:       s = SEL_PORT_B;
            ADDR_PERIPH_FLAGS: s = SEL_PERIPH_FLAGS;
            ADDR_COMPARATOR:   s = SEL_COMPARATOR;
            ADDR_OPTIONS:      s = SEL_OPTIONS;
            ADDR_DIR_A:        s = SEL_DIR_A;
            ADDR_DIR_B:        s = SEL_DIR_B;
            ADDR_PERIPH_EN:    s = SEL_PERIPH_EN;
            ADDR_RESET_CAUSE:  s = SEL_RESET_CAUSE;
            ADDR_SERIAL_MEM:   s = SEL_SERIAL_MEM;
            ADDR_VREF:         s = SEL_VREF;
            default:           s = SEL_NONE;
        endcase
        return s;
    endfunction

    logic [7:0]                plain_q [PLAIN_COUNT];
    logic [7:0]                cause_q;
    logic [7:0]                cause_soft;
    logic [7:0]                rd_word;
    logic [7:0]                flags_w;
    logic [PC_WIDTH-1:0]       pc_w;
    logic [PC_LATCH_WIDTH-1:0] latch_w;
    sfr_sel_t                  ptr_sel;
    sfr_sel_t                  ind_sel;
    sfr_sel_t                  raw_rd_sel;
    sfr_sel_t                  raw_wr_sel;
    sfr_sel_t                  rd_sel;
    sfr_sel_t                  wr_sel;
    logic                      wr_ok;
    logic                      wr_flags;
    logic                      wr_pc_low;
    logic                      wr_pc_latch;
    logic                      wr_cause;

    // indirect access goes through the pointer; pointing at itself reaches nothing
    assign ptr_sel     = decode_sel(plain_q[IDX_POINTER]);
    assign ind_sel     = (ptr_sel == SEL_INDIRECT) ? SEL_NONE : ptr_sel;
    assign raw_rd_sel  = decode_sel(rd_addr);
    assign raw_wr_sel  = decode_sel(wr_addr);
    assign rd_sel      = (raw_rd_sel == SEL_INDIRECT) ? ind_sel : raw_rd_sel;
    assign wr_sel      = (raw_wr_sel == SEL_INDIRECT) ? ind_sel : raw_wr_sel;

    // a reset in the same cycle wins over an instruction write
    assign wr_ok       = wr_en && !soft_rst;
    assign wr_flags    = wr_ok && (wr_sel == SEL_FLAGS);
    assign wr_pc_low   = wr_ok && (wr_sel == SEL_PC_LOW);
    assign wr_pc_latch = wr_ok && (wr_sel == SEL_PC_LATCH);
    assign wr_cause    = wr_ok && (wr_sel == SEL_RESET_CAUSE);

    core_flags_unit u_flags (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .soft_rst        (soft_rst),
        .wdt_reset_cause (wdt_reset_cause),
        .wr_en           (wr_flags),
        .wr_data         (wr_data),
        .upd_mask        (flag_upd_mask),
        .alu_z           (alu_z),
        .alu_dc          (alu_dc),
        .alu_c           (alu_c),
        .sub_op          (sub_op),
        .sleep_evt       (sleep_evt),
        .clrwdt_evt      (clrwdt_evt),
        .wdt_timeout_evt (wdt_timeout_evt),
        .flags_q         (flags_w)
    );

    program_counter_unit u_pc (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .soft_rst (soft_rst),
        .wr_low   (wr_pc_low),
        .wr_latch (wr_pc_latch),
        .wr_data  (wr_data),
        .pc_inc   (pc_inc),
        .pc_q     (pc_w),
        .latch_q  (latch_w)
    );

    // plain storage: only implemented bits are kept
    for (genvar i = 0; i < PLAIN_COUNT; i++)
    begin : g_plain
        logic       hit;
        logic [7:0] soft_val;
        assign hit      = wr_ok && (wr_sel == PLAIN_SEL[i]);
        assign soft_val = (plain_q[i] & PLAIN_KEEP[i])
                        | (PLAIN_POR[i] & ~PLAIN_KEEP[i]);
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                plain_q[i] <= PLAIN_POR[i];
            else if (soft_rst)
                plain_q[i] <= soft_val;
            else if (hit)
                plain_q[i] <= wr_data & PLAIN_MASK[i];
        end
    end

    // power-on flag survives other resets; brown-out flag clears on a brown-out
    assign cause_soft = {cause_q[7:1],
                         brownout_cause ? 1'b0 : cause_q[CAUSE_BROWNOUT]};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cause_q <= CAUSE_POR;
        else if (soft_rst)
            cause_q <= cause_soft;
        else if (wr_cause)
            cause_q <= wr_data & CAUSE_MASK;
    end

    always_comb
    begin
        rd_word = 8'h00;
        for (int i = 0; i < PLAIN_COUNT; i++)
        begin
            if (rd_sel == PLAIN_SEL[i])
                rd_word = plain_q[i];
        end
        case (rd_sel)
            SEL_PC_LOW:      rd_word = pc_w[7:0];
            SEL_FLAGS:       rd_word = flags_w;
            SEL_PC_LATCH:    rd_word = {3'b000, latch_w};
            SEL_RESET_CAUSE: rd_word = cause_q;
            default:         ;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rd_data_q <= 8'h00;
        else
            rd_data_q <= rd_word;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            core_flags <= FLAGS_POR;
        else
            core_flags <= flags_w;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            program_counter <= '0;
        else
            program_counter <= pc_w;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            indirect_pointer <= PLAIN_POR[IDX_POINTER];
        else
            indirect_pointer <= plain_q[IDX_POINTER];
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            interrupt_control <= PLAIN_POR[IDX_IRQ];
        else
            interrupt_control <= plain_q[IDX_IRQ];
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            core_options <= PLAIN_POR[IDX_OPTIONS];
        else
            core_options <= plain_q[IDX_OPTIONS];
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            port_a_direction <= PLAIN_POR[IDX_DIR_A];
        else
            port_a_direction <= plain_q[IDX_DIR_A];
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            port_b_direction <= PLAIN_POR[IDX_DIR_B];
        else
            port_b_direction <= plain_q[IDX_DIR_B];
    end

    sequence write_then_read_s(logic [7:0] a);
        wr_ok && wr_addr == a ##1 !wr_en && rd_addr == a;
    endsequence

    AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        rd_sel == SEL_NONE |=> rd_data_q == 8'h00)
        else $error("unimplemented location read nonzero");

    AST_RESERVED_BITS_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        write_then_read_s(ADDR_PORT_A) |=> rd_data_q[7:5] == 3'b000)
        else $error("unimplemented bits read nonzero");

    AST_BANK_MIRROR: assert property (@(posedge sys_clk) disable iff (rst)
        rd_addr == ADDR_FLAGS_B1 |=> rd_data_q == $past(flags_w))
        else $error("bank 1 flags location not the shared register");

    AST_MIRROR_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        write_then_read_s(ADDR_POINTER_B1) |=> rd_data_q == $past(wr_data, 2))
        else $error("pointer written in bank 1 not seen");

    AST_SOFT_VALUES: assert property (@(posedge sys_clk) disable iff (rst)
        soft_rst |=> plain_q[IDX_OPTIONS] == 8'hff && plain_q[IDX_DIR_A] == 8'h1f
            && plain_q[IDX_POINTER] == $past(plain_q[IDX_POINTER]) && pc_w == '0)
        else $error("other reset values wrong");

    AST_SOFT_BLOCKS_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        soft_rst && wr_en |=> cause_q[1] == $past(cause_q[1]))
        else $error("write taken during reset");

    AST_OUTPUT_TRACKS: assert property (@(posedge sys_clk) disable iff (rst)
        wr_flags && flag_upd_mask == 3'b000 && !sleep_evt && !clrwdt_evt && !wdt_timeout_evt
        |-> ##2 core_flags[7:5] == $past(wr_data[7:5], 2))
        else $error("flags output did not follow write");

    AST_LATCH_READ_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        rd_sel == SEL_PC_LATCH |=> rd_data_q[7:5] == 3'b000)
        else $error("latch read upper bits nonzero");

    AST_CAUSE_BITS_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        rd_sel == SEL_RESET_CAUSE |=> (rd_data_q & ~CAUSE_MASK) == 8'h00)
        else $error("reset cause unused bits nonzero");

    AST_SELF_POINTER_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        raw_rd_sel == SEL_INDIRECT && ptr_sel == SEL_INDIRECT |=> rd_data_q == 8'h00)
        else $error("indirect read through itself nonzero");

    AST_PC_LOW_SHARED: assert property (@(posedge sys_clk) disable iff (rst)
        rd_sel == SEL_PC_LOW |=> rd_data_q == $past(pc_w[7:0]))
        else $error("program counter low byte not shared");

    AST_BROWNOUT_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        soft_rst && brownout_cause |=> !cause_q[CAUSE_BROWNOUT])
        else $error("brown-out flag not cleared");

    AST_LATCH_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
        wr_pc_latch |=> latch_w == $past(wr_data[PC_LATCH_WIDTH-1:0]))
        else $error("latch write not held");

endmodule

//--- verilog/program_counter_unit.sv
`timescale 1ns/1ns
module program_counter_unit
    import sfr_map_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      soft_rst,
    input  wire logic                      wr_low,
    input  wire logic                      wr_latch,
    input  wire logic [7:0]                wr_data,
    input  wire logic                      pc_inc,
    output logic      [PC_WIDTH-1:0]       pc_q,
    output logic      [PC_LATCH_WIDTH-1:0] latch_q
);

    logic [PC_WIDTH-1:0] pc_d;

    // the latch reaches the upper bits only when the low byte is written
    assign pc_d = wr_low ? {latch_q, wr_data} : pc_inc ? pc_q + 1'b1 : pc_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pc_q    <= '0;
            latch_q <= '0;
        end
        else if (soft_rst)
        begin
            pc_q    <= '0;
            latch_q <= '0;
        end
        else
        begin
            pc_q <= pc_d;
            if (wr_latch)
                latch_q <= wr_data[PC_LATCH_WIDTH-1:0];
        end
    end

    AST_PC_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
        !soft_rst && wr_low |=> pc_q == {$past(latch_q), $past(wr_data)})
        else $error("program counter not loaded from latch");
    AST_LATCH_HELD: assert property (@(posedge sys_clk) disable iff (rst)
        !soft_rst && wr_latch && !wr_low && !pc_inc |=> pc_q == $past(pc_q))
        else $error("latch write moved the program counter");

endmodule
